//--- common/ssx_alu_if.sv
// Purpose: Carries an opcode and operands to the arithmetic unit and its verdict back.
// Assumes: Purely combinational; the core holds all state.
// Notes: None.
`timescale 1ns/1ps
`default_nettype none

interface ssx_alu_if;
	logic [13:0] op;
	logic [7:0] wreg;
	logic [7:0] fval;
	logic [7:0] res;
	logic c;
	logic dc;
	logic z;
	logic upd_c;
	logic upd_dc;
	logic upd_z;
	logic to_w;
	logic to_file;
	logic to_dir;
	logic [1:0] dir_idx;
	logic bad;

	modport core (output op, wreg, fval, input res, c, dc, z, upd_c, upd_dc, upd_z,
		to_w, to_file, to_dir, dir_idx, bad);
	modport alu (input op, wreg, fval, output res, c, dc, z, upd_c, upd_dc, upd_z,
		to_w, to_file, to_dir, dir_idx, bad);
endinterface : ssx_alu_if

`default_nettype wire

//--- common/ssx_cfg.svh
// Purpose: Offsets, encodings, field positions and reset values of the executor.
// Assumes: Included by the package and by every design file that needs a number.
// Notes: Byte addresses on a 32-bit AXI4-Lite bus, one aligned word per register.
`ifndef SSX_CFG_SVH
`define SSX_CFG_SVH

// Register byte offsets.
`define SSX_OFF_INSTR 8'h00
`define SSX_OFF_WREG 8'h04
`define SSX_OFF_STATUS 8'h08
`define SSX_OFF_PTR 8'h0C
`define SSX_OFF_FDATA 8'h10
`define SSX_OFF_DIRS 8'h14

// Bus geometry and answers.
`define SSX_ADDR_W 8
`define SSX_RESP_OKAY 2'h0
`define SSX_RESP_SLVERR 2'h2

// Status and control bit positions.
`define SSX_BIT_C 0
`define SSX_BIT_DC 1
`define SSX_BIT_Z 2
`define SSX_BIT_BAD 3
`define SSX_BIT_BUSY 16

// Opcode patterns, compared against the top bits of the 14-bit word.
`define SSX_ENC_LIT_SUB 5'h1E
`define SSX_ENC_LIT_XOR 6'h3A
`define SSX_ENC_REG_SUB 6'h02
`define SSX_ENC_SWAP 6'h0E
`define SSX_ENC_REG_XOR 6'h06
`define SSX_ENC_DIR_LOAD 11'h00C
`define SSX_DIR_MIN 3'h5
`define SSX_DIR_MAX 3'h7

// Sizes and reset values.
`define SSX_FILE_DEPTH 128
`define SSX_FADDR_W 7
`define SSX_INSTR_W 14
`define SSX_RST_BYTE 8'h00
`define SSX_RST_INSTR 14'h0000

`endif

//--- common/ssx_pkg.sv
// Purpose: Types shared by the executor modules.
// Assumes: Widths come from the configuration header.
// Notes: The whole core state is one packed struct.
`include "ssx_cfg.svh"

package ssx_pkg;

	// One-hot instruction phases; idle waits for a new opcode.
	typedef enum logic [4:0] {
		PH_IDLE = 5'h01,
		PH_DECODE = 5'h02,
		PH_READ = 5'h04,
		PH_PROCESS = 5'h08,
		PH_WRITE = 5'h10
	} ssx_phase_t;

	typedef struct packed {
		ssx_phase_t phase;
		logic [`SSX_INSTR_W-1:0] instr;
		logic [7:0] wreg;
		logic c;
		logic dc;
		logic z;
		logic bad;
		logic [`SSX_FADDR_W-1:0] ptr;
		logic [7:0] fval;
		logic [7:0] res;
		logic rc;
		logic rdc;
		logic rz;
		logic [2:0][7:0] dir;
		logic [`SSX_FILE_DEPTH-1:0][7:0] fmem;
		logic aw_v;
		logic [`SSX_ADDR_W-1:0] aw_a;
		logic w_v;
		logic [31:0] w_d;
		logic [3:0] w_s;
		logic awready;
		logic wready;
		logic bvalid;
		logic [1:0] bresp;
		logic arready;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
	} ssx_state_t;

endpackage : ssx_pkg

//--- rtl/ssx_alu.sv
// Purpose: Decodes one opcode and computes its result, flags and destination.
// Assumes: Operands are stable from the process phase to the write phase.
// Notes: Unknown opcodes and out-of-range direction selects raise bad only.
`timescale 1ns/1ps
`default_nettype none
`include "ssx_cfg.svh"

module ssx_alu (
	// Link to the core.
	ssx_alu_if.alu bus
);
	import ssx_pkg::*;

	// Minuend minus subtrahend as {carry, digit carry, result}; carry high means no borrow.
	function automatic logic [9:0] ssx_sub(input logic [7:0] a, input logic [7:0] b);
		logic [8:0] full;
		logic [4:0] low;
		full = {1'b0, a} - {1'b0, b};
		low = {1'b0, a[3:0]} - {1'b0, b[3:0]};
		ssx_sub = {~full[8], ~low[4], full[7:0]};
	endfunction : ssx_sub

	logic [9:0] sub_lit;
	logic [9:0] sub_reg;
	logic dest_f;

	assign dest_f = bus.op[7];

	// RQ10 literal minus working
	assign sub_lit = ssx_sub(bus.op[7:0], bus.wreg);
	// RQ4 file minus working
	assign sub_reg = ssx_sub(bus.fval, bus.wreg);

	// Decode table; defaults ahead of the branches and the zero test after them give every output a value so nothing latches.
	always_comb begin
		bus.res = `SSX_RST_BYTE;
		bus.c = 1'b0;
		bus.dc = 1'b0;
		bus.upd_c = 1'b0;
		bus.upd_dc = 1'b0;
		bus.upd_z = 1'b0;
		bus.to_w = 1'b0;
		bus.to_file = 1'b0;
		bus.to_dir = 1'b0;
		bus.dir_idx = 2'(bus.op[2:0] - `SSX_DIR_MIN);
		bus.bad = 1'b0;
		if (bus.op[13:9] == `SSX_ENC_LIT_SUB) begin
			// RQ10 literal subtract op
			{bus.c, bus.dc, bus.res} = sub_lit;
			{bus.upd_c, bus.upd_dc, bus.upd_z, bus.to_w} = 4'hF;
		end else if (bus.op[13:8] == `SSX_ENC_LIT_XOR) begin
			// RQ7 RQ8 literal xor, Z only
			bus.res = bus.wreg ^ bus.op[7:0];
			bus.upd_z = 1'b1;
			bus.to_w = 1'b1;
		end else if (bus.op[13:8] == `SSX_ENC_REG_SUB) begin
			// RQ4 destination by direction
			{bus.c, bus.dc, bus.res} = sub_reg;
			{bus.upd_c, bus.upd_dc, bus.upd_z} = 3'h7;
			bus.to_w = ~dest_f;
			bus.to_file = dest_f;
		end else if (bus.op[13:8] == `SSX_ENC_SWAP) begin
			// RQ5 nibble swap, no flags
			bus.res = {bus.fval[3:0], bus.fval[7:4]};
			bus.to_w = ~dest_f;
			bus.to_file = dest_f;
		end else if (bus.op[13:8] == `SSX_ENC_REG_XOR) begin
			// RQ9 register xor, Z only
			bus.res = bus.wreg ^ bus.fval;
			bus.upd_z = 1'b1;
			bus.to_w = ~dest_f;
			bus.to_file = dest_f;
		end else if (bus.op[13:3] == `SSX_ENC_DIR_LOAD) begin
			// RQ6 select 5 to 7 only
			bus.res = bus.wreg;
			bus.to_dir = (bus.op[2:0] >= `SSX_DIR_MIN) && (bus.op[2:0] <= `SSX_DIR_MAX);
			bus.bad = ~bus.to_dir;
		end else begin
			bus.bad = 1'b1;
		end
		// RQ1 RQ2 RQ3 zero flag
		bus.z = (bus.res == `SSX_RST_BYTE);
	end

endmodule : ssx_alu

`default_nettype wire

//--- rtl/ssx_top.sv
// Purpose: Executes subtract, swap, xor and direction-load opcodes written over AXI4-Lite.
// Assumes: One clock, synchronous active-low reset, one write and one read in flight.
// Notes: An opcode runs in four phases; register writes during a run are refused.
//
// Functional notes
// RQ1: Positive subtract result sets C, clears Z.
// RQ2: Zero subtract result sets C and Z.
// RQ3: Negative result clears C and Z, wraps.
// RQ4: Register subtract is file minus working.
// RQ5: Nibble swap to chosen destination, flags kept.
// RQ6: Direction load copies working, selects 5-7.
// RQ7: Literal xor result goes to working.
// RQ8: Literal xor decoded by 111010, Z only.
// RQ9: Register xor to chosen destination, Z only.
// RQ10: Literal subtract is literal minus working.
// RQ11: Every opcode takes four phases.
// RQ12: Digit carry clear on low-nibble borrow.
`timescale 1ns/1ps
`default_nettype none
`include "ssx_cfg.svh"

module ssx_top (
	// Clock and reset.
	input wire logic aclk,
	input wire logic aresetn,
	// Write address channel.
	input wire logic awvalid,
	output logic awready,
	input wire logic [`SSX_ADDR_W-1:0] awaddr,
	// Write data channel.
	input wire logic wvalid,
	output logic wready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	// Write response channel.
	output logic bvalid,
	input wire logic bready,
	output logic [1:0] bresp,
	// Read address channel.
	input wire logic arvalid,
	output logic arready,
	input wire logic [`SSX_ADDR_W-1:0] araddr,
	// Read data channel.
	output logic rvalid,
	input wire logic rready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	// Port direction registers and run state.
	output logic [7:0] port_dir5,
	output logic [7:0] port_dir6,
	output logic [7:0] port_dir7,
	output logic busy
);
	import ssx_pkg::*;

	// Applies byte strobes of a bus write onto an old word.
	function automatic logic [31:0] ssx_merge(input logic [31:0] old, input logic [31:0] d,
		input logic [3:0] s);
		logic [31:0] m;
		m = old;
		for (int i = 0; i < 4; i++) begin
			if (s[i]) begin
				m[i*8 +: 8] = d[i*8 +: 8];
			end
		end
		ssx_merge = m;
	endfunction : ssx_merge

	// Drops the byte-lane bits so any address inside a word hits it.
	function automatic logic [`SSX_ADDR_W-1:0] ssx_word(input logic [`SSX_ADDR_W-1:0] a);
		ssx_word = {a[`SSX_ADDR_W-1:2], 2'b00};
	endfunction : ssx_word

	localparam ssx_state_t RST = '{
		phase: PH_IDLE, instr: `SSX_RST_INSTR, wreg: `SSX_RST_BYTE, c: 1'b0, dc: 1'b0,
		z: 1'b0, bad: 1'b0, ptr: '0, fval: `SSX_RST_BYTE, res: `SSX_RST_BYTE, rc: 1'b0,
		rdc: 1'b0, rz: 1'b0, dir: '1, fmem: '0, aw_v: 1'b0, aw_a: '0, w_v: 1'b0,
		w_d: '0, w_s: '0, awready: 1'b1, wready: 1'b1, bvalid: 1'b0,
		bresp: `SSX_RESP_OKAY, arready: 1'b1, rvalid: 1'b0, rdata: '0,
		rresp: `SSX_RESP_OKAY};

	ssx_state_t st_ff;
	ssx_state_t nxt_st;
	logic [31:0] wr_word;
	logic is_busy;

	ssx_alu_if alu_bus ();

	ssx_alu u_alu (
		.bus(alu_bus)
	);

	// Operands reach the unit straight from state, so they hold still from the process phase to the end of a run.
	assign alu_bus.op = st_ff.instr;
	assign alu_bus.wreg = st_ff.wreg;
	assign alu_bus.fval = st_ff.fval;

	assign is_busy = (st_ff.phase != PH_IDLE);

	// Old value of the addressed register, for byte-strobe merging.
	always_comb begin
		case (ssx_word(st_ff.aw_a))
			`SSX_OFF_INSTR: wr_word = {18'h0, st_ff.instr};
			`SSX_OFF_WREG: wr_word = {24'h0, st_ff.wreg};
			`SSX_OFF_STATUS: wr_word = {28'h0, st_ff.bad, st_ff.z, st_ff.dc, st_ff.c};
			`SSX_OFF_PTR: wr_word = {25'h0, st_ff.ptr};
			`SSX_OFF_FDATA: wr_word = {24'h0, st_ff.fmem[st_ff.ptr]};
			default: wr_word = 32'h0000_0000;
		endcase
		wr_word = ssx_merge(wr_word, st_ff.w_d, st_ff.w_s);
	end

	// Next-state logic for the bus slave and the phase sequencer.
	always_comb begin
		nxt_st = st_ff;
		// Address and data are taken independently and held until both are present.
		if (st_ff.awready && awvalid) begin
			nxt_st.aw_v = 1'b1;
			nxt_st.aw_a = awaddr;
		end
		if (st_ff.wready && wvalid) begin
			nxt_st.w_v = 1'b1;
			nxt_st.w_d = wdata;
			nxt_st.w_s = wstrb;
		end
		if (st_ff.bvalid && bready) begin
			nxt_st.bvalid = 1'b0;
		end
		// A run owns the working register, flags and file, so bus writes then are refused.
		if (st_ff.aw_v && st_ff.w_v && !st_ff.bvalid) begin
			nxt_st.aw_v = 1'b0;
			nxt_st.w_v = 1'b0;
			nxt_st.bvalid = 1'b1;
			nxt_st.bresp = `SSX_RESP_OKAY;
			if (is_busy) begin
				nxt_st.bresp = `SSX_RESP_SLVERR;
			end else begin
				case (ssx_word(st_ff.aw_a))
					`SSX_OFF_INSTR: begin
						nxt_st.instr = wr_word[`SSX_INSTR_W-1:0];
						nxt_st.phase = PH_DECODE;
					end
					`SSX_OFF_WREG: nxt_st.wreg = wr_word[7:0];
					`SSX_OFF_STATUS: begin
						nxt_st.c = wr_word[`SSX_BIT_C];
						nxt_st.dc = wr_word[`SSX_BIT_DC];
						nxt_st.z = wr_word[`SSX_BIT_Z];
						nxt_st.bad = wr_word[`SSX_BIT_BAD];
					end
					`SSX_OFF_PTR: nxt_st.ptr = wr_word[`SSX_FADDR_W-1:0];
					`SSX_OFF_FDATA: nxt_st.fmem[st_ff.ptr] = wr_word[7:0];
					default: nxt_st.bresp = `SSX_RESP_SLVERR;
				endcase
			end
		end
		nxt_st.awready = ~nxt_st.aw_v;
		nxt_st.wready = ~nxt_st.w_v;
		// Reads answer one cycle after the address is taken.
		if (st_ff.rvalid && rready) begin
			nxt_st.rvalid = 1'b0;
			nxt_st.arready = 1'b1;
		end
		if (st_ff.arready && arvalid) begin
			nxt_st.arready = 1'b0;
			nxt_st.rvalid = 1'b1;
			nxt_st.rresp = `SSX_RESP_OKAY;
			nxt_st.rdata = 32'h0000_0000;
			case (ssx_word(araddr))
				`SSX_OFF_INSTR: begin
					nxt_st.rdata[`SSX_INSTR_W-1:0] = st_ff.instr;
					nxt_st.rdata[`SSX_BIT_BUSY] = is_busy;
				end
				`SSX_OFF_WREG: nxt_st.rdata[7:0] = st_ff.wreg;
				`SSX_OFF_STATUS: nxt_st.rdata[3:0] = {st_ff.bad, st_ff.z, st_ff.dc, st_ff.c};
				`SSX_OFF_PTR: nxt_st.rdata[`SSX_FADDR_W-1:0] = st_ff.ptr;
				`SSX_OFF_FDATA: nxt_st.rdata[7:0] = st_ff.fmem[st_ff.ptr];
				`SSX_OFF_DIRS: nxt_st.rdata[23:0] = st_ff.dir;
				default: nxt_st.rresp = `SSX_RESP_SLVERR;
			endcase
		end
		// RQ11 four-phase sequence
		case (st_ff.phase)
			PH_IDLE: begin
			end
			PH_DECODE: nxt_st.phase = PH_READ;
			PH_READ: begin
				// Operand fetch from the file addressed by the opcode.
				nxt_st.fval = st_ff.fmem[st_ff.instr[`SSX_FADDR_W-1:0]];
				nxt_st.phase = PH_PROCESS;
			end
			PH_PROCESS: begin
				// RQ1 RQ2 RQ3 RQ12 capture result flags
				nxt_st.res = alu_bus.res;
				nxt_st.rc = alu_bus.c;
				nxt_st.rdc = alu_bus.dc;
				nxt_st.rz = alu_bus.z;
				nxt_st.phase = PH_WRITE;
			end
			PH_WRITE: begin
				// RQ4 RQ5 RQ9 write destination
				if (alu_bus.to_w) begin
					nxt_st.wreg = st_ff.res;
				end
				if (alu_bus.to_file) begin
					nxt_st.fmem[st_ff.instr[`SSX_FADDR_W-1:0]] = st_ff.res;
				end
				// RQ6 direction register load
				if (alu_bus.to_dir) begin
					nxt_st.dir[alu_bus.dir_idx] = st_ff.wreg;
				end
				// RQ8 RQ9 selective flag update
				if (alu_bus.upd_c) begin
					nxt_st.c = st_ff.rc;
				end
				if (alu_bus.upd_dc) begin
					nxt_st.dc = st_ff.rdc;
				end
				if (alu_bus.upd_z) begin
					nxt_st.z = st_ff.rz;
				end
				// Sticky until software clears it; no bus write can land during a run.
				if (alu_bus.bad) begin
					nxt_st.bad = 1'b1;
				end
				nxt_st.phase = PH_IDLE;
			end
			default: nxt_st.phase = PH_IDLE;
		endcase
	end

	// Single state register.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			st_ff <= RST;
		end else begin
			st_ff <= nxt_st;
		end
	end

	// Outputs come straight from state bits.
	assign awready = st_ff.awready;
	assign wready = st_ff.wready;
	assign bvalid = st_ff.bvalid;
	assign bresp = st_ff.bresp;
	assign arready = st_ff.arready;
	assign rvalid = st_ff.rvalid;
	assign rdata = st_ff.rdata;
	assign rresp = st_ff.rresp;
	assign port_dir5 = st_ff.dir[0];
	assign port_dir6 = st_ff.dir[1];
	assign port_dir7 = st_ff.dir[2];
	assign busy = is_busy;

endmodule : ssx_top

`default_nettype wire

//--- testbench/ssx_top_assertions.sv
// Purpose: Concurrent checks on the executor's bus and run ports.
// Assumes: Sees only the ports of the top module.
// Notes: Cycle figures follow the agreed bus and run timing.
`timescale 1ns/1ps
`default_nettype none
`include "ssx_cfg.svh"

module ssx_top_assertions (
	// Clock and reset.
	input wire logic aclk,
	input wire logic aresetn,
	// Write channels.
	input wire logic awvalid,
	input wire logic awready,
	input wire logic [`SSX_ADDR_W-1:0] awaddr,
	input wire logic wvalid,
	input wire logic wready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic bvalid,
	input wire logic bready,
	input wire logic [1:0] bresp,
	// Read channels.
	input wire logic arvalid,
	input wire logic arready,
	input wire logic [`SSX_ADDR_W-1:0] araddr,
	input wire logic rvalid,
	input wire logic rready,
	input wire logic [31:0] rdata,
	input wire logic [1:0] rresp,
	// Run state.
	input wire logic [7:0] port_dir5,
	input wire logic [7:0] port_dir6,
	input wire logic [7:0] port_dir7,
	input wire logic busy
);
	// One clock domain, so clock and reset are given once.
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);

	chk_run_length: assert property ($rose(busy) |-> busy[*4] ##1 !busy)
		else $error("run length wrong");
	chk_run_start: assert property ($rose(busy) |-> $rose(bvalid))
		else $error("run not started by write");
	chk_bresp_hold: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
		else $error("write answer dropped");
	chk_rdata_hold: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
		else $error("read answer dropped");
	chk_write_answer: assert property (awvalid && awready && wvalid && wready |-> ##2 bvalid)
		else $error("write answer late");
	chk_read_answer: assert property (arvalid && arready |=> rvalid && !arready)
		else $error("read answer late");
	// Direction registers change only as the commit of a run.
	chk_dir_commit: assert property ($changed({port_dir5, port_dir6, port_dir7}) |-> $past(busy))
		else $error("direction changed outside a run");
	chk_ro_refused: assert property (awvalid && awready && wvalid && wready &&
		awaddr[7:2] == 6'h05 |-> ##2 bvalid && bresp == 2'h2)
		else $error("read only write accepted");
	chk_unmapped_read: assert property (arvalid && arready && araddr[7:2] > 6'h05 |=>
		rresp == 2'h2 && rdata == 32'h0)
		else $error("unmapped read accepted");

	cover property ($rose(busy));
	cover property (bvalid && !bready);
	cover property (rvalid && rresp == 2'h2);
endmodule : ssx_top_assertions

`default_nettype wire

//--- testbench/ssx_top_tb.sv
// Purpose: Self-checking bench for the executor top.
// Assumes: Bus tasks act as an AXI4-Lite master; a plain model predicts results.
// Notes: Operands come from a fixed seed; ready lines stall at random.
`timescale 1ns/1ps
`default_nettype none
`include "ssx_cfg.svh"

module ssx_top_tb;
	logic aclk = 1'b0, aresetn = 1'b0;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic [7:0] awaddr = 8'h00, araddr = 8'h00;
	logic [31:0] wdata = 32'h0;
	logic [3:0] wstrb = 4'hF;
	logic awready, wready, bvalid, arready, rvalid, busy;
	logic [1:0] bresp, rresp;
	logic [31:0] rdata;
	logic [7:0] port_dir5, port_dir6, port_dir7;
	int failures = 0, checks_done = 0, cycles = 0;
	// Model state.
	logic [7:0] mw = 8'h00, mf [128];
	logic [7:0] mdir [3] = '{8'hFF, 8'hFF, 8'hFF};
	logic mc = 1'b0, mdc = 1'b0, mz = 1'b0, mbad = 1'b0;

	ssx_top i_ssx_top (.aclk, .aresetn, .awvalid, .awready, .awaddr, .wvalid, .wready,
		.wdata, .wstrb, .bvalid, .bready, .bresp, .arvalid, .arready, .araddr, .rvalid,
		.rready, .rdata, .rresp, .port_dir5, .port_dir6, .port_dir7, .busy);

	always #5 aclk = ~aclk;

	task automatic conclude();
		if (failures == 0 && checks_done > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask : conclude

	// A hung handshake ends the run as a failure.
	always @(posedge aclk) begin
		cycles <= cycles + 1;
		if (cycles == 8000) begin
			failures++;
			conclude();
		end
	end

	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			failures++;
			$display("Error %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk

	// The leading edge keeps two tasks from driving one signal in one step.
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
		output logic [1:0] r);
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		wstrb <= s;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'($urandom);
		do begin
			@(posedge aclk);
			if (awready && awvalid) awvalid <= 1'b0;
			if (wready && wvalid) wvalid <= 1'b0;
			if (bvalid === 1'b1) bready <= !bready;
		end while (!(bvalid === 1'b1 && bready));
		r = bresp;
	endtask : wr

	task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'($urandom);
		do begin
			@(posedge aclk);
			if (arready && arvalid) arvalid <= 1'b0;
			if (rvalid === 1'b1) rready <= !rready;
		end while (!(rvalid === 1'b1 && rready));
		d = rdata;
		r = rresp;
	endtask : rd

	function automatic logic [7:0] sub8(input logic [7:0] a, input logic [7:0] b);
		mc = (a >= b);
		mdc = (a[3:0] >= b[3:0]);
		mz = (a == b);
		return a - b;
	endfunction : sub8

	task automatic put(input logic d, input logic [6:0] f, input logic [7:0] v);
		if (d) mf[f] = v;
		else mw = v;
	endtask : put

	task automatic model(input logic [13:0] op);
		logic [7:0] v;
		if (op[13:9] == 5'h1E) begin
			mw = sub8(op[7:0], mw);
		end else if (op[13:8] == 6'h3A) begin
			mw = mw ^ op[7:0];
			mz = (mw == 8'h00);
		end else if (op[13:8] == 6'h02) begin
			put(op[7], op[6:0], sub8(mf[op[6:0]], mw));
		end else if (op[13:8] == 6'h0E) begin
			put(op[7], op[6:0], {mf[op[6:0]][3:0], mf[op[6:0]][7:4]});
		end else if (op[13:8] == 6'h06) begin
			v = mf[op[6:0]] ^ mw;
			mz = (v == 8'h00);
			put(op[7], op[6:0], v);
		end else if (op[13:3] == 11'h00C && op[2:0] >= 3'h5) begin
			mdir[op[2:0] - 3'h5] = mw;
		end else begin
			mbad = 1'b1;
		end
	endtask : model

	task automatic run(input logic [13:0] op, input logic [6:0] f);
		logic [31:0] d;
		logic [1:0] r;
		wr(8'h00, {18'h0, op}, 4'hF, r);
		chk("instr_resp", {30'h0, r}, 32'h0);
		model(op);
		// The read is taken three or four edges after the answer rises, inside the run.
		rd(8'h00, d, r);
		chk("instr_busy", d, {15'h0, 1'b1, 2'h0, op});
		while (busy === 1'b1) @(posedge aclk);
		rd(8'h04, d, r);
		chk("wreg", d, {24'h0, mw});
		rd(8'h08, d, r);
		chk("status", d, {28'h0, mbad, mz, mdc, mc});
		wr(8'h0C, {25'h0, f}, 4'hF, r);
		rd(8'h10, d, r);
		chk("file", d, {24'h0, mf[f]});
		rd(8'h14, d, r);
		chk("dirs", d, {8'h0, mdir[2], mdir[1], mdir[0]});
		chk("dir_pins", {8'h0, port_dir7, port_dir6, port_dir5}, {8'h0, mdir[2], mdir[1], mdir[0]});
	endtask : run

	initial begin
		logic [31:0] d;
		logic [1:0] r;
		logic [7:0] w, v, k;
		logic [6:0] f;
		logic [13:0] op;
		d = $urandom(32'h8525);
		repeat (10) @(posedge aclk);
		aresetn <= 1'b1;
		// Reset values, refusals and a masked byte lane.
		rd(8'h14, d, r);
		chk("dirs_rst", d, 32'h00FFFFFF);
		rd(8'h20, d, r);
		chk("unmapped", {r, d[29:0]}, 32'h80000000);
		wr(8'h14, 32'h0, 4'hF, r);
		chk("ro_write", {30'h0, r}, 32'h2);
		wr(8'h04, 32'h55, 4'hE, r);
		rd(8'h04, d, r);
		chk("strobe", d, 32'h0);
		// Every opcode kind; a third of the cases force equal operands.
		for (int i = 0; i < 36; i++) begin
			w = 8'($urandom);
			v = 8'($urandom);
			k = 8'($urandom);
			f = 7'($urandom);
			if (i % 18 < 6) begin
				v = w;
				k = w;
			end
			wr(8'h04, {24'h0, w}, 4'hF, r);
			wr(8'h0C, {25'h0, f}, 4'hF, r);
			wr(8'h10, {24'h0, v}, 4'hF, r);
			mw = w;
			mf[f] = v;
			case (i % 6)
				0: op = {5'h1E, i[3], k};
				1: op = {6'h3A, k};
				2: op = {6'h02, i[2], f};
				3: op = {6'h0E, i[2], f};
				4: op = {6'h06, i[2], f};
				default: op = {11'h00C, 3'(4 + (i / 6) % 4)};
			endcase
			run(op, f);
		end
		conclude();
	end
endmodule : ssx_top_tb

bind ssx_top ssx_top_assertions i_ssx_top_assertions (.aclk, .aresetn, .awvalid, .awready,
	.awaddr, .wvalid, .wready, .wdata, .wstrb, .bvalid, .bready, .bresp, .arvalid,
	.arready, .araddr, .rvalid, .rready, .rdata, .rresp, .port_dir5, .port_dir6,
	.port_dir7, .busy);

`default_nettype wire
